//--- inc/jadc_pkg.sv
// package: register map, field layout, state codes and timing for jack accessory detect
package jadc_pkg;

  // register offsets
  localparam logic [7:0] ADDR_STATE   = 8'h19;
  localparam logic [7:0] ADDR_TEST    = 8'h1A;
  localparam logic [7:0] ADDR_SCRATCH = 8'h1B;
  localparam logic [7:0] ADDR_CLKCTL  = 8'h1C;
  localparam logic [7:0] ADDR_ENABLE  = 8'h1D;

  // field positions
  localparam int FORCE_BIT     = 7;
  localparam int DEB_BIT       = 7;
  localparam int RSVD_TEST_BIT = 6;
  localparam int REP_LSB       = 4;
  localparam int WID_LSB       = 2;
  localparam int AMP_LSB       = 0;
  localparam int SCANCLK_BIT   = 7;
  localparam int ACTIVE_BIT    = 7;

  // reset values
  localparam logic [7:0] STATE_RST   = 8'h80;
  localparam logic [7:0] TEST_RST    = 8'h05;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  localparam logic [7:0] CLKCTL_RST  = 8'h01;
  localparam logic [7:0] ENABLE_RST  = 8'h00;

  // accessory state codes
  localparam logic [6:0] ST_NONE     = 7'h00;
  localparam logic [6:0] ST_HS_SLV   = 7'h01;
  localparam logic [6:0] ST_HS_R2    = 7'h02;
  localparam logic [6:0] ST_MONO_GND = 7'h0A;
  localparam logic [6:0] ST_MONO_TIP = 7'h0C;
  localparam logic [6:0] ST_MONO_FLT = 7'h0E;
  localparam logic [6:0] ST_HP_BOTH  = 7'h10;
  localparam logic [6:0] ST_HP_LEFT  = 7'h11;
  localparam logic [6:0] ST_HP_RIGHT = 7'h12;
  localparam logic [6:0] ST_LO_BOTH  = 7'h1A;
  localparam logic [6:0] ST_LO_RIGHT = 7'h1B;
  localparam logic [6:0] ST_LO_LEFT  = 7'h1C;
  localparam logic [6:0] ST_UNSUP    = 7'h1F;

  // contact classification vector bits
  localparam int CMP_TIP_LOAD = 0;
  localparam int CMP_R1_LOAD  = 1;
  localparam int CMP_R1_GND   = 2;
  localparam int CMP_R1_TIP   = 3;
  localparam int CMP_R2_GND   = 4;
  localparam int CMP_SLV_GND  = 5;
  localparam int CMP_LINEOUT  = 6;
  localparam int CMP_W        = 7;

  // timing
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned DEB_INS_SHORT_US = 3000;
  localparam int unsigned DEB_REM_SHORT_US = 12000;
  localparam int unsigned DEB_INS_LONG_US  = 20000;
  localparam int unsigned DEB_REM_LONG_US  = 80000;
  localparam int unsigned PW_25_US         = 25;
  localparam int unsigned PW_50_US         = 50;
  localparam int unsigned PW_100_US        = 100;
  localparam int unsigned PW_200_US        = 200;
  localparam int unsigned DEB_INS_SHORT_CYC = DEB_INS_SHORT_US * CLK_MHZ;
  localparam int unsigned DEB_REM_SHORT_CYC = DEB_REM_SHORT_US * CLK_MHZ;
  localparam int unsigned DEB_INS_LONG_CYC  = DEB_INS_LONG_US * CLK_MHZ;
  localparam int unsigned DEB_REM_LONG_CYC  = DEB_REM_LONG_US * CLK_MHZ;
  localparam int unsigned PW_25_CYC         = PW_25_US * CLK_MHZ;
  localparam int unsigned PW_50_CYC         = PW_50_US * CLK_MHZ;
  localparam int unsigned PW_100_CYC        = PW_100_US * CLK_MHZ;
  localparam int unsigned PW_200_CYC        = PW_200_US * CLK_MHZ;
  localparam int DEB_W = 25;
  localparam int PW_W  = 16;

  // pulse amplitude divisors of the supply, by code
  localparam logic [6:0] AMP_DIV_00 = 7'h24;
  localparam logic [6:0] AMP_DIV_01 = 7'h48;
  localparam logic [6:0] AMP_DIV_10 = 7'h12;
  localparam logic [6:0] AMP_DIV_11 = 7'h09;

  typedef enum logic [1:0] {PT_IDLE, PT_PULSE, PT_GAP} jadc_pt_state_t;

endpackage : jadc_pkg

//--- core/jadc_debounce.sv
// file: comparator debounce with separate rise and fall stability times
`timescale 1ns/10ps
`default_nettype none
module jadc_debounce
  import jadc_pkg::*;
#(
  parameter int CW = jadc_pkg::DEB_W
) (
  // clock and reset
  input  wire logic          ref_clk,
  input  wire logic          srst,
  // synchronised comparator level and stability targets
  input  wire logic          sample,
  input  wire logic [CW-1:0] rise_cyc,
  input  wire logic [CW-1:0] fall_cyc,
  // accepted level
  output var  logic          level_q
);
  import jadc_pkg::*;

  localparam logic [CW-1:0] ONE = 1;

  logic [CW-1:0] cnt_q;
  logic          last_q;
  logic [CW-1:0] target;

  assign target = sample ? rise_cyc : fall_cyc;

  // count stable cycles; any toggle restarts the count
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_q   <= '0;
      last_q  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      last_q <= sample;
      if (sample != last_q) begin
        cnt_q <= '0;
      end else if (sample != level_q) begin
        if (cnt_q + ONE >= target) begin
          level_q <= sample;
          cnt_q   <= '0;
        end else begin
          cnt_q <= cnt_q + ONE;
        end
      end else begin
        cnt_q <= '0;
      end
    end
  end

  a_deb_toggle_restart: assert property (@(posedge ref_clk) disable iff (srst)
    (sample != last_q) |=> (cnt_q == '0) && $stable(level_q))
    else $error("debounce count not restarted on toggle");

  a_deb_full_time: assert property (@(posedge ref_clk) disable iff (srst)
    (level_q != $past(level_q)) |-> ($past(cnt_q) + ONE >= $past(target)))
    else $error("debounced level changed before full interval");

endmodule : jadc_debounce
`default_nettype wire

//--- core/jadc_pulse_tester.sv
// file: repeated detection pulse test sequencer with combined result
`timescale 1ns/10ps
`default_nettype none
module jadc_pulse_tester
  import jadc_pkg::*;
#(
  parameter int PW = jadc_pkg::PW_W
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // test request and settings
  input  wire logic                        start,
  input  wire logic [1:0]                  repeat_sel,
  input  wire logic [PW-1:0]               width_cyc,
  // contact classification sampled at end of each pulse
  input  wire logic [jadc_pkg::CMP_W-1:0]  cmp,
  // test drive and result
  output var  logic                        test_pulse_q,
  output var  logic                        busy_q,
  output var  logic                        done_q,
  output var  logic [jadc_pkg::CMP_W-1:0]  result_q
);
  import jadc_pkg::*;

  localparam logic [PW-1:0] ONE = 1;

  jadc_pt_state_t    st_q;
  logic [PW-1:0]     cnt_q;
  logic [3:0]        left_q;
  logic [CMP_W-1:0]  acc_q;
  logic [3:0]        runs_q;

  // sequencer: pulse, sample, short gap, repeat
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q         <= PT_IDLE;
      cnt_q        <= '0;
      left_q       <= 4'h0;
      acc_q        <= '0;
      runs_q       <= 4'h0;
      test_pulse_q <= 1'b0;
      busy_q       <= 1'b0;
      done_q       <= 1'b0;
      result_q     <= '0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        PT_IDLE: begin
          if (start) begin
            st_q         <= PT_PULSE;
            cnt_q        <= width_cyc;
            left_q       <= 4'((4'h1 << repeat_sel) - 4'h1);
            acc_q        <= '1;
            runs_q       <= 4'h0;
            test_pulse_q <= 1'b1;
            busy_q       <= 1'b1;
          end
        end
        PT_PULSE: begin
          if (cnt_q <= ONE) begin
            test_pulse_q <= 1'b0;
            runs_q       <= runs_q + 4'h1;
            if (left_q == 4'h0) begin
              st_q     <= PT_IDLE;
              busy_q   <= 1'b0;
              done_q   <= 1'b1;
              result_q <= acc_q & cmp;
            end else begin
              st_q   <= PT_GAP;
              acc_q  <= acc_q & cmp;
              left_q <= left_q - 4'h1;
            end
          end else begin
            cnt_q <= cnt_q - ONE;
          end
        end
        PT_GAP: begin
          st_q         <= PT_PULSE;
          cnt_q        <= width_cyc;
          test_pulse_q <= 1'b1;
        end
        default: begin
          st_q <= PT_IDLE;
        end
      endcase
    end
  end

  a_tester_run_count: assert property (@(posedge ref_clk) disable iff (srst)
    done_q |-> (runs_q == 4'((4'h1 << $past(repeat_sel, 2))))
      || ($past(repeat_sel) != $past(repeat_sel, 2)))
    else $error("pulse test ran wrong number of times");

endmodule : jadc_pulse_tester
`default_nettype wire

//--- core/jadc_top.sv
// file: jack accessory detect configuration, reporting and scan clock control
`timescale 1ns/10ps
`default_nettype none
module jadc_top
  import jadc_pkg::*;
#(
  parameter int unsigned DEB_INS_SHORT = jadc_pkg::DEB_INS_SHORT_CYC,
  parameter int unsigned DEB_REM_SHORT = jadc_pkg::DEB_REM_SHORT_CYC,
  parameter int unsigned DEB_INS_LONG  = jadc_pkg::DEB_INS_LONG_CYC,
  parameter int unsigned DEB_REM_LONG  = jadc_pkg::DEB_REM_LONG_CYC,
  parameter int unsigned PW_25         = jadc_pkg::PW_25_CYC,
  parameter int unsigned PW_50         = jadc_pkg::PW_50_CYC,
  parameter int unsigned PW_100        = jadc_pkg::PW_100_CYC,
  parameter int unsigned PW_200        = jadc_pkg::PW_200_CYC
) (
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  // register access port
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output var  logic [7:0]                  reg_rdata_q,
  // jack comparators (asynchronous)
  input  wire logic                        jack_sense_raw,
  input  wire logic                        button_raw,
  input  wire logic [jadc_pkg::CMP_W-1:0]  contact_cmp_raw,
  // contact configuration and test drive
  output var  logic [6:0]                  contact_cfg_q,
  output var  logic                        test_pulse_q,
  output var  logic [1:0]                  pulse_amp_q,
  output var  logic [6:0]                  pulse_div_q,
  // status and scan clock
  output var  logic                        jack_present_q,
  output var  logic                        button_press_q,
  output var  logic                        detect_busy_q,
  output var  logic                        scan_clk_en_q
);
  import jadc_pkg::*;

  logic [7:0]       test_q;
  logic [7:0]       scratch_q;
  logic [7:0]       clkctl_q;
  logic             active_q;
  logic             force_q;
  logic [6:0]       state_wr_q;
  logic [6:0]       det_state_q;
  logic             active_d1_q;
  logic             jack_d1_q;
  logic [CMP_W+1:0] sync1_q;
  logic [CMP_W+1:0] sync2_q;
  logic [DEB_W-1:0] ins_cyc;
  logic [DEB_W-1:0] rem_cyc;
  logic [PW_W-1:0]  width_cyc;
  logic             start;
  logic             done;
  logic [CMP_W-1:0] result;
  logic [7:0]       rdata_d;

  // map a pulse width code to clock cycles
  function automatic logic [PW_W-1:0] pulse_cycles(input logic [1:0] code);
    case (code)
      2'b00:   pulse_cycles = PW_W'(PW_50);
      2'b01:   pulse_cycles = PW_W'(PW_25);
      2'b10:   pulse_cycles = PW_W'(PW_100);
      default: pulse_cycles = PW_W'(PW_200);
    endcase
  endfunction : pulse_cycles

  // map an amplitude code to its supply divisor
  function automatic logic [6:0] amp_divisor(input logic [1:0] code);
    case (code)
      2'b00:   amp_divisor = AMP_DIV_00;
      2'b01:   amp_divisor = AMP_DIV_01;
      2'b10:   amp_divisor = AMP_DIV_10;
      default: amp_divisor = AMP_DIV_11;
    endcase
  endfunction : amp_divisor

  // turn combined contact results into an accessory state code
  function automatic logic [6:0] classify(input logic present, input logic [CMP_W-1:0] c);
    logic [6:0] base;
    logic       tip;
    logic       r1;
    base = ST_NONE;
    tip  = c[CMP_TIP_LOAD];
    r1   = c[CMP_R1_LOAD];
    if (!present) begin
      classify = ST_NONE;
    end else if (c[CMP_R2_GND] && c[CMP_SLV_GND]) begin
      if (!tip && !r1) begin
        classify = ST_UNSUP;
      end else if (c[CMP_LINEOUT]) begin
        classify = (tip && r1) ? ST_LO_BOTH : (tip ? ST_LO_LEFT : ST_LO_RIGHT);
      end else begin
        classify = (tip && r1) ? ST_HP_BOTH : (tip ? ST_HP_LEFT : ST_HP_RIGHT);
      end
    end else begin
      if (c[CMP_R1_GND]) begin
        base = ST_MONO_GND;
      end else if (c[CMP_R1_TIP]) begin
        base = ST_MONO_TIP;
      end else if (r1) begin
        base = ST_HS_SLV;
      end else begin
        base = ST_MONO_FLT;
      end
      // mic on ring2 with sleeve grounded takes the next code
      classify = c[CMP_R2_GND] ? base : 7'(base + 7'h01);
    end
  endfunction : classify

  // two-stage synchronisers for all comparator pins
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {button_raw, jack_sense_raw, contact_cmp_raw};
      sync2_q <= sync1_q;
    end
  end

  // debounce times chosen by the select bit
  assign ins_cyc = test_q[DEB_BIT] ? DEB_W'(DEB_INS_LONG) : DEB_W'(DEB_INS_SHORT);
  assign rem_cyc = test_q[DEB_BIT] ? DEB_W'(DEB_REM_LONG) : DEB_W'(DEB_REM_SHORT);
  assign width_cyc = pulse_cycles(test_q[WID_LSB+:2]);

  // jack sense: open means inserted; removal uses the longer time
  jadc_debounce #(.CW(DEB_W)) u_jack_debounce_select (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .sample   (sync2_q[CMP_W]),
    .rise_cyc (ins_cyc),
    .fall_cyc (rem_cyc),
    .level_q  (jack_present_q)
  );

  // sleep-mode button press uses the insertion time both ways
  jadc_debounce #(.CW(DEB_W)) u_button_deb (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .sample   (sync2_q[CMP_W+1]),
    .rise_cyc (ins_cyc),
    .fall_cyc (ins_cyc),
    .level_q  (button_press_q)
  );

  // detection begins on the rising edge of the active bit while a jack is present
  assign start = active_q && !active_d1_q && jack_present_q;

  jadc_pulse_tester #(.PW(PW_W)) u_tester (
    .ref_clk      (ref_clk),
    .srst         (srst),
    .start        (start),
    .repeat_sel   (test_q[REP_LSB+:2]),
    .width_cyc    (width_cyc),
    .cmp          (sync2_q[CMP_W-1:0]),
    .test_pulse_q (test_pulse_q),
    .busy_q       (detect_busy_q),
    .done_q       (done),
    .result_q     (result)
  );

  // register writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      test_q     <= TEST_RST;
      scratch_q  <= SCRATCH_RST;
      clkctl_q   <= CLKCTL_RST;
      active_q   <= ENABLE_RST[ACTIVE_BIT];
      force_q    <= STATE_RST[FORCE_BIT];
      state_wr_q <= STATE_RST[6:0];
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_TEST:    test_q <= reg_wdata & ~(8'h01 << RSVD_TEST_BIT);
        ADDR_SCRATCH: scratch_q <= reg_wdata;
        ADDR_CLKCTL:  clkctl_q <= reg_wdata;
        ADDR_ENABLE:  active_q <= reg_wdata[ACTIVE_BIT];
        ADDR_STATE: begin
          force_q    <= reg_wdata[FORCE_BIT];
          state_wr_q <= reg_wdata[6:0];
        end
        default: begin
        end
      endcase
    end
  end

  // edge history for active and jack presence
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      active_d1_q <= 1'b0;
      jack_d1_q   <= 1'b0;
    end else begin
      active_d1_q <= active_q;
      jack_d1_q   <= jack_present_q;
    end
  end

  // detected state: cleared on removal, loaded on test completion
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      det_state_q <= ST_NONE;
    end else if (reg_wr && reg_addr == ADDR_STATE && reg_wdata[FORCE_BIT] && !force_q) begin
      det_state_q <= state_wr_q;
    end else if (jack_d1_q && !jack_present_q) begin
      det_state_q <= ST_NONE;
    end else if (done) begin
      det_state_q <= classify(jack_present_q, result);
    end
  end

  // drives toward the jack and the scan clock
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      contact_cfg_q <= ST_NONE;
      pulse_amp_q   <= TEST_RST[AMP_LSB+:2];
      pulse_div_q   <= amp_divisor(TEST_RST[AMP_LSB+:2]);
      scan_clk_en_q <= CLKCTL_RST[SCANCLK_BIT];
    end else begin
      contact_cfg_q <= force_q ? det_state_q : state_wr_q;
      pulse_amp_q   <= test_q[AMP_LSB+:2];
      pulse_div_q   <= amp_divisor(test_q[AMP_LSB+:2]);
      scan_clk_en_q <= clkctl_q[SCANCLK_BIT];
    end
  end

  // read data selection
  always_comb begin
    case (reg_addr)
      ADDR_STATE:   rdata_d = {force_q, force_q ? det_state_q : state_wr_q};
      ADDR_TEST:    rdata_d = test_q;
      ADDR_SCRATCH: rdata_d = scratch_q;
      ADDR_CLKCTL:  rdata_d = clkctl_q;
      ADDR_ENABLE:  rdata_d = {active_q, 7'h00};
      default:      rdata_d = 8'h00;
    endcase
  end

  // registered read answer
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  a_test_rsvd_zero: assert property (@(posedge ref_clk) disable iff (srst)
    reg_wr && reg_addr == ADDR_TEST |=> test_q[RSVD_TEST_BIT] == 1'b0)
    else $error("reserved test bit became set");

  a_field_reset: assert property (@(posedge ref_clk)
    srst |=> test_q[WID_LSB+:2] == 2'b01 && test_q[AMP_LSB+:2] == 2'b01)
    else $error("width or amplitude reset code wrong");

  a_scan_clk_follow: assert property (@(posedge ref_clk) disable iff (srst)
    reg_wr && reg_addr == ADDR_CLKCTL |=> ##1 scan_clk_en_q == $past(reg_wdata[SCANCLK_BIT], 2))
    else $error("scan clock enable does not follow bit 7");

  a_detect_start: assert property (@(posedge ref_clk) disable iff (srst)
    start && !detect_busy_q |=> detect_busy_q && test_pulse_q)
    else $error("detection did not start on activation");

  a_force_apply: assert property (@(posedge ref_clk) disable iff (srst)
    !$past(force_q) |-> contact_cfg_q == $past(state_wr_q))
    else $error("forced state not applied to contacts");

  a_removal_none: assert property (@(posedge ref_clk) disable iff (srst)
    jack_d1_q && !jack_present_q && !(reg_wr && reg_addr == ADDR_STATE) |=> det_state_q == ST_NONE)
    else $error("removal did not report nothing inserted");

  a_deb_select: assert property (@(posedge ref_clk) disable iff (srst)
    test_q[DEB_BIT] |-> ins_cyc == DEB_W'(DEB_INS_LONG) && rem_cyc == DEB_W'(DEB_REM_LONG))
    else $error("debounce times do not follow select bit");

endmodule : jadc_top
`default_nettype wire

//--- sim/jadc_accessory_model.sv
// accessory on the jack: sense switch, button and contact comparators
`timescale 1ns/10ps
`default_nettype none
module jadc_accessory_model (
  // clock and test drive
  input  wire logic       ref_clk,
  input  wire logic       test_pulse_q,
  // accessory controls
  input  wire logic       plugged,
  input  wire logic       btn,
  input  wire logic       drop,
  input  wire logic [6:0] feat,
  // comparator levels
  output var  logic       jack_sense_raw,
  output var  logic       button_raw,
  output var  logic [6:0] contact_cmp_raw
);
  int n = 0;
  int lo = 0;
  // quiet levels at time zero
  initial begin
    jack_sense_raw = 1'b0;
    button_raw = 1'b0;
    contact_cmp_raw = 7'h00;
  end
  // number the pulses of one burst; a long low starts a new burst
  always @(posedge ref_clk) begin
    lo <= test_pulse_q ? 0 : lo + 1;
    if (test_pulse_q && lo != 0) n <= (lo > 1) ? 1 : n + 1;
  end
  // sense shorted and contacts floating when empty
  always @(posedge ref_clk) begin
    jack_sense_raw <= plugged;
    button_raw <= plugged & btn;
    if (!plugged) contact_cmp_raw <= ~contact_cmp_raw;
    else contact_cmp_raw <= (drop && n == 2) ? feat & 7'h7E : feat;
  end
endmodule : jadc_accessory_model
`default_nettype wire

//--- sim/jack_accessory_detect_config_tb_top.sv
// testbench: registers, debounce timing, pulse test and state codes
`timescale 1ns/10ps
`default_nettype none
module jack_accessory_detect_config_tb_top;
  import jadc_pkg::*;
  localparam int PWS[4] = '{6, 5, 8, 10};
  localparam int DBS[4] = '{20, 40, 60, 80};
  localparam int DIVS[4] = '{36, 72, 18, 9};
  localparam logic [7:0] RA[5] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h40};
  localparam logic [7:0] RV[5] = '{8'h80, 8'h05, 8'h00, 8'h01, 8'h00};
  localparam logic [6:0] FT[9] = '{7'h13, 7'h23, 7'h15, 7'h19, 7'h33, 7'h73, 7'h33, 7'h72, 7'h30};
  logic ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, pv = 1'b0;
  logic plugged = 1'b0, btn = 1'b0, drop = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_q, rv, wv;
  logic [6:0] feat = 7'h00, contact_cfg_q, pulse_div_q, cmp;
  logic [1:0] pulse_amp_q;
  logic js, bt, test_pulse_q, jack_present_q, button_press_q, detect_busy_q, scan_clk_en_q;
  int error_cnt = 0, n_tests = 0, hi = 0, ru = 0, h0 = 0, r0 = 0;
  // clock
  always #2 ref_clk = ~ref_clk;
  // count test pulses and their high cycles
  always @(posedge ref_clk) begin
    pv <= test_pulse_q;
    if (test_pulse_q) hi <= hi + 1;
    if (test_pulse_q && !pv) ru <= ru + 1;
  end
  jadc_top #(.DEB_INS_SHORT(DBS[0]), .DEB_REM_SHORT(DBS[1]), .DEB_INS_LONG(DBS[2]),
    .DEB_REM_LONG(DBS[3]), .PW_25(PWS[1]), .PW_50(PWS[0]), .PW_100(PWS[2]),
    .PW_200(PWS[3])) dut (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .jack_sense_raw(js),
    .button_raw(bt), .contact_cmp_raw(cmp), .contact_cfg_q(contact_cfg_q),
    .test_pulse_q(test_pulse_q), .pulse_amp_q(pulse_amp_q), .pulse_div_q(pulse_div_q),
    .jack_present_q(jack_present_q), .button_press_q(button_press_q),
    .detect_busy_q(detect_busy_q), .scan_clk_en_q(scan_clk_en_q));
  jadc_accessory_model acc (.ref_clk(ref_clk), .test_pulse_q(test_pulse_q), .plugged(plugged),
    .btn(btn), .drop(drop), .feat(feat), .jack_sense_raw(js), .button_raw(bt),
    .contact_cmp_raw(cmp));
  // expected state code for a contact picture
  function automatic logic [6:0] code(input logic [6:0] c);
    if (!(c[4] && c[5])) return (c[2] ? 7'h0A : c[3] ? 7'h0C : c[1] ? 7'h01 : 7'h0E) + 7'(!c[4]);
    if (!c[0] && !c[1]) return 7'h1F;
    if (c[6]) return c[0] && c[1] ? 7'h1A : c[1] ? 7'h1B : 7'h1C;
    return c[0] && c[1] ? 7'h10 : c[0] ? 7'h11 : 7'h12;
  endfunction : code
  task give_verdict;
    if (error_cnt == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  // one register write; outputs settle one edge after it is taken
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : wr
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_q;
  endtask : rd
  // change a raw level with one glitch, then time the accepted level
  task deb(input bit b, input logic l, input int n);
    @(posedge ref_clk);
    if (b) btn <= l; else plugged <= l;
    repeat (n / 2) @(posedge ref_clk);
    if (b) btn <= !l; else plugged <= !l;
    @(posedge ref_clk);
    if (b) btn <= l; else plugged <= l;
    repeat (n - 1) @(posedge ref_clk);
    #1 chk("early", 8'(b ? button_press_q : jack_present_q), 8'(!l));
    repeat (8) @(posedge ref_clk);
    #1 chk("late", 8'(b ? button_press_q : jack_present_q), 8'(l));
  endtask : deb
  // activate the device and check pulses and the reported code
  task det(input logic [6:0] f, input logic [1:0] r, input logic [1:0] w, input logic d);
    logic [6:0] e;
    e = code(d ? f & 7'h7E : f);
    @(posedge ref_clk);
    feat <= f;
    drop <= d;
    wr(ADDR_TEST, {2'b00, r, w, 2'b01});
    wr(ADDR_ENABLE, 8'h00);
    #1 h0 = hi;
    r0 = ru;
    wr(ADDR_ENABLE, 8'h80);
    #1 chk("busy", 8'(detect_busy_q), 8'h01);
    for (int k = 0; k < 900 && (detect_busy_q !== 1'b0 || ru == r0); k++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    #1 chk("runs", 8'(ru - r0), 8'(1 << r));
    chk("idle", 8'(detect_busy_q), 8'h00);
    chk("width", 8'(hi - h0), 8'((1 << r) * PWS[w]));
    chk("cfg", {1'b0, contact_cfg_q}, {1'b0, e});
    rd(ADDR_STATE, rv);
    chk("state", rv, {1'b1, e});
  endtask : det
  // watchdog
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
  // main sequence
  initial begin
    void'($urandom(32'h896a05e0));
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(RA[i], rv);
      chk("rst", rv, RV[i]);
    end
    chk("amp0", 8'(pulse_amp_q), 8'h01);
    chk("div0", 8'(pulse_div_q), 8'h48);
    chk("cfg0", 8'(contact_cfg_q), 8'h00);
    wr(ADDR_CLKCTL, 8'h00);
    #1 chk("sc0", 8'(scan_clk_en_q), 8'h00);
    for (int i = 0; i < 4; i++) begin
      wv = (8'($urandom) & 8'hFC) | 8'(i);
      wr(ADDR_TEST, wv);
      #1 chk("amp", 8'(pulse_amp_q), 8'(i));
      chk("div", 8'(pulse_div_q), 8'(DIVS[i]));
      rd(ADDR_TEST, rv);
      chk("test", rv, wv & 8'hBF);
    end
    wr(ADDR_TEST, 8'h05);
    deb(0, 1, DBS[0]);
    deb(1, 1, DBS[0]);
    deb(1, 0, DBS[0]);
    for (int i = 0; i < 9; i++)
      det(FT[i], 2'(i), i == 6 ? 2'b10 : 2'(i + 1), i == 6);
    wr(ADDR_STATE, 8'h0C);
    #1 chk("frc", 8'(contact_cfg_q), 8'h0C);
    wr(ADDR_STATE, 8'h80);
    rd(ADDR_STATE, rv);
    chk("copy", rv, 8'h8C);
    for (int i = 1; i >= 0; i--) begin
      wr(ADDR_CLKCTL, {i[0], 7'h00});
      wr(8'h66, 8'hF1);
      wr(8'h6F, 8'(i));
      wr(8'h66, 8'h00);
      #1 chk("sc", 8'(scan_clk_en_q), 8'(i));
      rd(8'h6F, rv);
      chk("unmap", rv, 8'h00);
    end
    deb(0, 0, DBS[1]);
    @(posedge ref_clk);
    #1 chk("gone", 8'(contact_cfg_q), 8'h00);
    wr(ADDR_ENABLE, 8'h00);
    #1 r0 = ru;
    wr(ADDR_ENABLE, 8'h80);
    repeat (30) @(posedge ref_clk);
    #1 chk("noact", 8'(ru - r0), 8'h00);
    wr(ADDR_TEST, 8'h85);
    deb(0, 1, DBS[2]);
    deb(0, 0, DBS[3]);
    give_verdict();
  end
endmodule : jack_accessory_detect_config_tb_top
`default_nettype wire
